// ---- hw/tmr_interval.sv ----
/*
 * Timer interval counter fed by the preset register.
 * Assumes the preset is stable while the counter runs.
 */
`timescale 1ns/100ps
`default_nettype none
module tmr_interval
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [tmr_stby_pkg::TW-1:0] preset_i,
   input wire logic restart_i,
   input wire logic slow_clk_i,
   output logic expire_o
);
   import tmr_stby_pkg::*;

   // Prescale counter and interval counter.
   logic [7:0] pre_r, pre_nxt;
   logic [TW-1:0] cnt_r, cnt_nxt;
   logic exp_r, exp_nxt;
   logic tick;

   // One tick every 64 or 128 system clocks; interval is preset+1 ticks.
   always_comb begin
      tick = (pre_r == (slow_clk_i ? 8'(TCLK_DIV_HI - 1) :
                        8'(TCLK_DIV_LO - 1)));
      pre_nxt = tick ? 8'h00 : pre_r + 8'h01;
      cnt_nxt = cnt_r;
      exp_nxt = 1'b0;
      if (restart_i) begin
         pre_nxt = 8'h00;
         cnt_nxt = preset_i;
      end else if (tick) begin
         if (cnt_r == '0) begin
            exp_nxt = 1'b1;
            cnt_nxt = preset_i;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   // Registers only.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_r <= 8'h00;
         cnt_r <= TMR_RST;
         exp_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign expire_o = exp_r;

   // Expiry only follows a prescaler wrap.
   exp_tick_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i) exp_r |-> $past(tick))
      else $error("Expiry without tick.");
endmodule
`default_nettype wire

// ---- hw/tmr_stby_exec.sv ----
/*
 * Execution logic for timer load, standby, status test and carry-on-ones.
 * Assumes the fetch unit presents each instruction with a valid strobe and,
 * for two-word forms, both words at once; ROM data returns combinationally.
 */
`timescale 1ns/100ps
`default_nettype none
module tmr_stby_exec
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic instr_valid_i,
   input wire logic [tmr_stby_pkg::IW-1:0] instr_word0_i,
   input wire logic [tmr_stby_pkg::IW-1:0] instr_word1_i,
   input wire logic [tmr_stby_pkg::DW-1:0] acc_i,
   input wire logic [tmr_stby_pkg::DW-1:0] bank0_register_i,
   input wire logic [tmr_stby_pkg::PAGE_W-1:0] rom_page_select_i,
   input wire logic [tmr_stby_pkg::PAIR_W-1:0] reg_pair_i,
   input wire logic [tmr_stby_pkg::IW-1:0] rom_data_i,
   input wire tmr_stby_pkg::status_in_t status_i,
   input wire logic slow_timer_clk_i,
   output logic [tmr_stby_pkg::ROM_AW-1:0] rom_addr_o,
   output logic [tmr_stby_pkg::DW-1:0] bank0_index_o,
   output logic [tmr_stby_pkg::DW-1:0] acc_o,
   output logic acc_we_o,
   output tmr_stby_pkg::flags_t flags_o,
   output logic status_we_o,
   output logic carry_we_o,
   output logic [tmr_stby_pkg::TW-1:0] timer_preset_o,
   output logic timer_expire_o,
   output logic standby_o,
   output logic [tmr_stby_pkg::DW-1:0] wake_select_o,
   output logic exec_ready_o
);
   import tmr_stby_pkg::*;

   // Masked opcode match, used for several decodes.
   function automatic logic op_is(input logic [IW-1:0] w,
                                  input logic [IW-1:0] op,
                                  input logic [IW-1:0] m);
      op_is = ((w & m) == (op & m));
   endfunction

   // Decoded instruction strobes.
   logic d_nib_wr, d_nib_rd, d_imm, d_rom, d_stby, d_st_reg, d_st_imm;
   logic d_ones;
   logic hi_sel; // High nibble when set.

   // Architectural state and its next values.
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic [DW-1:0] wake_r, wake_nxt;
   core_state_t state_r, state_nxt;
   logic [DW-1:0] acc_r, acc_nxt;
   logic acc_we_r, acc_we_nxt;
   flags_t flags_r, flags_nxt;
   logic st_we_r, st_we_nxt, cy_we_r, cy_we_nxt;
   logic restart_r, restart_nxt;

   // Status-test helpers.
   logic [DW-1:0] mask;
   logic [DW-1:0] live;
   logic match;
   logic wake;
   logic [DW-1:0] ones_run;
   logic timer_exp;

   // Decoding happens only while running; standby ignores the fetch.
   always_comb begin
      logic go;
      go = instr_valid_i && (state_r == RUN);
      d_nib_wr = go && op_is(instr_word0_i, OP_TMR_NIB_WR, OP_TMR_NIB_MASK);
      d_nib_rd = go && op_is(instr_word0_i, OP_TMR_NIB_RD, OP_TMR_NIB_MASK);
      d_imm = go && (instr_word0_i == OP_TMR_IMM);
      d_rom = go && (instr_word0_i == OP_TMR_ROM);
      d_stby = go && (instr_word0_i == OP_STANDBY);
      d_st_reg = go && op_is(instr_word0_i, OP_STATUS_TEST_INSTRUCTION_REG, OP_STATUS_TEST_INSTRUCTION_MASK);
      d_st_imm = go && (instr_word0_i == OP_STATUS_TEST_INSTRUCTION_IMM);
      d_ones = go && (instr_word0_i == OP_CARRY_ONES);
      hi_sel = instr_word0_i[NIB_SEL_BIT];
   end

   // The ROM address is always presented; page on top, pair below.
   assign rom_addr_o = {rom_page_select_i, reg_pair_i};
   assign bank0_index_o = instr_word0_i[DW-1:0];

   // Status compare: the four wake/test sources, sense inputs merged.
   // Sense a and b share one mask bit since only four bits are given.
   always_comb begin
      live = {status_i.timer_done | timer_exp, status_i.key_input_any,
              status_i.key_io_any,
              status_i.sense_input_a | status_i.sense_input_b};
      mask = d_st_reg ? bank0_register_i : instr_word1_i[DW-1:0];
      match = |(mask & live);
      wake = |(wake_r & live);
   end

   // Low-order run of ones: each bit survives only if all below are one.
   always_comb begin
      ones_run[0] = acc_i[0];
      for (int i = 1; i < DW; i++) begin
         ones_run[i] = acc_i[i] & ones_run[i-1];
      end
   end

   // Next-state for the whole group; each instruction done in one cycle.
   always_comb begin
      tmr_nxt = tmr_r;
      wake_nxt = wake_r;
      state_nxt = state_r;
      acc_nxt = acc_r;
      acc_we_nxt = 1'b0;
      flags_nxt = flags_r;
      st_we_nxt = 1'b0;
      cy_we_nxt = 1'b0;
      restart_nxt = 1'b0;
      if (d_nib_wr) begin
         if (hi_sel) begin
            tmr_nxt[HI_LSB +: DW] = acc_i;
            tmr_nxt[HI_ZERO_BIT] = 1'b0;
         end else begin
            tmr_nxt[MID_LSB +: DW] = acc_i;
            tmr_nxt[MID_ZERO_BIT] = 1'b0;
         end
         restart_nxt = 1'b1;
      end else if (d_nib_rd) begin
         acc_nxt = hi_sel ? tmr_r[HI_LSB +: DW] : tmr_r[MID_LSB +: DW];
         acc_we_nxt = 1'b1;
      end else if (d_imm) begin
         // Word bits 9..0 carry t1,t9,t8,t7,t6,t0,t5,t4,t3,t2.
         tmr_nxt = {instr_word1_i[8:5], instr_word1_i[3:0],
                    instr_word1_i[9], instr_word1_i[4]};
         restart_nxt = 1'b1;
      end else if (d_rom) begin
         tmr_nxt = rom_data_i;
         restart_nxt = 1'b1;
      end else if (d_stby) begin
         wake_nxt = instr_word1_i[DW-1:0];
         state_nxt = STANDBY;
      end else if (d_st_reg || d_st_imm) begin
         flags_nxt.status_flag = match;
         st_we_nxt = 1'b1;
      end else if (d_ones) begin
         flags_nxt.carry_flag = &acc_i;
         acc_nxt = ones_run;
         acc_we_nxt = 1'b1;
         cy_we_nxt = 1'b1;
      end
      // Release: selection stays until a chosen source goes active.
      if (state_r == STANDBY && wake) begin
         state_nxt = RUN;
      end
   end

   // Registers only.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tmr_r <= TMR_RST;
         wake_r <= WAKE_RST;
         state_r <= RUN;
         acc_r <= 4'h0;
         acc_we_r <= 1'b0;
         flags_r <= '0;
         st_we_r <= 1'b0;
         cy_we_r <= 1'b0;
         restart_r <= 1'b0;
      end else begin
         tmr_r <= tmr_nxt;
         wake_r <= wake_nxt;
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         acc_we_r <= acc_we_nxt;
         flags_r <= flags_nxt;
         st_we_r <= st_we_nxt;
         cy_we_r <= cy_we_nxt;
         restart_r <= restart_nxt;
      end
   end

   // Interval counter driven by the preset.
   tmr_interval u_tmr_interval (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .preset_i(tmr_r),
      .restart_i(restart_r),
      .slow_clk_i(slow_timer_clk_i),
      .expire_o(timer_exp)
   );

   assign acc_o = acc_r;
   assign acc_we_o = acc_we_r;
   assign flags_o = flags_r;
   assign status_we_o = st_we_r;
   assign carry_we_o = cy_we_r;
   assign timer_preset_o = tmr_r;
   assign timer_expire_o = timer_exp;
   assign standby_o = (state_r == STANDBY);
   assign wake_select_o = wake_r;
   // Fetch may present a new instruction whenever the core runs.
   assign exec_ready_o = (state_r == RUN);

   nib_hi_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      d_nib_wr && hi_sel |=> tmr_r[9:6] == $past(acc_i) && !tmr_r[1])
      else $error("High nibble write wrong.");
   nib_mid_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      d_nib_wr && !hi_sel |=> tmr_r[5:2] == $past(acc_i) && !tmr_r[0])
      else $error("Middle nibble write wrong.");
   imm_map_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      d_imm |=> tmr_r[1] == $past(instr_word1_i[9])
      && tmr_r[0] == $past(instr_word1_i[4]))
      else $error("Immediate map wrong.");
   rom_load_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      d_rom |=> tmr_r == $past(rom_data_i))
      else $error("ROM load wrong.");
   stby_hold_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      standby_o && !wake |=> standby_o && $stable(wake_r))
      else $error("Standby left early.");
   stby_enter_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      d_stby |=> standby_o) else $error("Standby not entered.");
   status_test_instruction_flag_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      (d_st_reg || d_st_imm) |=> st_we_r && flags_r.status_flag == $past(match))
      else $error("Status flag wrong.");
   carry_ones_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i)
      d_ones |=> flags_r.carry_flag == ($past(acc_i) == 4'hf)
      && acc_o == $past(ones_run)) else $error("Carry wrong.");

   stby_c: cover property (@(posedge sys_clk_i) d_stby ##[1:50] !standby_o);
   status_test_instruction_c: cover property (@(posedge sys_clk_i) d_st_imm && match);
   ones_c: cover property (@(posedge sys_clk_i) d_ones && acc_i == 4'hf);
endmodule
`default_nettype wire

// ---- hw/tmr_stby_pkg.sv ----
/*
 * Package for the timer, standby and status-test execution block.
 * Holds opcodes, field positions, reset values and the carried structs.
 * Assumes a 10-bit instruction word and a 4-bit data path.
 */
package tmr_stby_pkg;

   // Instruction word and data widths.
   localparam int IW = 10;
   localparam int DW = 4;
   localparam int TW = 10;
   localparam int PAGE_W = 2;
   localparam int PAIR_W = 8;
   localparam int ROM_AW = PAGE_W + PAIR_W;

   // First words of the instructions handled here.
   localparam logic [9:0] OP_TMR_NIB_WR = 10'h0bf; // Bit 5 picks high.
   localparam logic [9:0] OP_TMR_NIB_MASK = 10'h3df;
   localparam logic [9:0] OP_TMR_IMM = 10'h0df;
   localparam logic [9:0] OP_TMR_ROM = 10'h0ff;
   localparam logic [9:0] OP_STANDBY = 10'h051;
   localparam logic [9:0] OP_STATUS_TEST_INSTRUCTION_REG = 10'h060; // Low 4 bits index.
   localparam logic [9:0] OP_STATUS_TEST_INSTRUCTION_MASK = 10'h3f0;
   localparam logic [9:0] OP_STATUS_TEST_INSTRUCTION_IMM = 10'h071;
   localparam logic [9:0] OP_CARRY_ONES = 10'h35b;
   // Read-back of a timer nibble into the accumulator.
   localparam logic [9:0] OP_TMR_NIB_RD = 10'h3bf;

   // Field positions.
   localparam int NIB_SEL_BIT = 5;
   localparam int HI_LSB = 6;
   localparam int MID_LSB = 2;
   localparam int HI_ZERO_BIT = 1;
   localparam int MID_ZERO_BIT = 0;

   // Reset values.
   localparam logic [9:0] TMR_RST = 10'h000;
   localparam logic [3:0] WAKE_RST = 4'h0;

   // Timer clock divisors in system clock periods.
   localparam int TCLK_DIV_LO = 64;
   localparam int TCLK_DIV_HI = 128;

   // Status inputs gathered for the status tests.
   typedef struct packed {
      logic sense_input_a;
      logic sense_input_b;
      logic key_io_any;
      logic key_input_any;
      logic timer_done;
   } status_in_t;

   // Flags produced by an instruction.
   typedef struct packed {
      logic status_flag;
      logic carry_flag;
   } flags_t;

   typedef enum logic {
      RUN,
      STANDBY
   } core_state_t;

endpackage

// ---- sim/tb_tmr_stby_exec.sv ----
/*
 * Self-checking bench for the timer, standby and status-test block.
 * Assumes the block registers its answer at the taking edge and that the
 * program memory returns its word in the same cycle as the address.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_tmr_stby_exec;
   import tmr_stby_pkg::*;
   logic sys_clk_i, rst_b_i, instr_valid_i, slow_timer_clk_i;
   logic [IW-1:0] instr_word0_i, instr_word1_i;
   logic [DW-1:0] acc_i, bank0_register_i;
   logic [PAGE_W-1:0] rom_page_select_i;
   logic [PAIR_W-1:0] reg_pair_i;
   wire logic [IW-1:0] rom_data_i;
   status_in_t status_i;
   logic [ROM_AW-1:0] rom_addr_o;
   logic [DW-1:0] bank0_index_o, acc_o, wake_select_o;
   logic acc_we_o, status_we_o, carry_we_o, timer_expire_o;
   logic standby_o, exec_ready_o;
   flags_t flags_o;
   logic [TW-1:0] timer_preset_o;
   int num_errors = 0;
   int cmp_count = 0;
   logic [9:0] vals [5] = '{10'h3ff, 10'h2aa, 10'h155, 10'h001, 10'h200};

   // The program memory model scrambles its address so a wrong address
   // and a wrong bit order both show up in the loaded preset.
   assign rom_data_i = rom_addr_o ^ 10'h2c5;

   tmr_stby_exec u_tmr_stby_exec (.sys_clk_i, .rst_b_i, .instr_valid_i,
      .instr_word0_i, .instr_word1_i, .acc_i, .bank0_register_i,
      .rom_page_select_i, .reg_pair_i, .rom_data_i, .status_i,
      .slow_timer_clk_i, .rom_addr_o, .bank0_index_o, .acc_o, .acc_we_o,
      .flags_o, .status_we_o, .carry_we_o, .timer_preset_o, .timer_expire_o,
      .standby_o, .wake_select_o, .exec_ready_o);

   // Compares one value, counting and reporting any difference.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Presents one instruction for a single taking edge; on return the
   // registered results and the one-cycle pulses are both visible.
   task automatic issue(input logic [9:0] w0, input logic [9:0] w1);
      @(posedge sys_clk_i);
      #1;
      instr_valid_i = 1'b1;
      instr_word0_i = w0;
      instr_word1_i = w1;
      @(posedge sys_clk_i);
      #1;
      instr_valid_i = 1'b0;
   endtask

   // Counts cycles until the next expiry pulse, bounded against a hang.
   task automatic period(output int n);
      n = 0;
      do begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end while (timer_expire_o !== 1'b1 && n < 3000);
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Second word of the immediate load, scattered as the wire order asks.
   function automatic logic [9:0] imm_word(input logic [9:0] t);
      return {t[1], t[9:6], t[0], t[5:2]};
   endfunction

   // Live statuses in mask order: timer, key inputs, key lines, sense.
   function automatic logic [3:0] live(input status_in_t s);
      return {s.timer_done, s.key_input_any, s.key_io_any,
              s.sense_input_a | s.sense_input_b};
   endfunction

   // Low-order run of ones that survives the all-ones carry test.
   function automatic logic [3:0] ones_run(input logic [3:0] a);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 4 && a[i]; i++) begin
         r[i] = 1'b1;
      end
      return r;
   endfunction

   // Free-running 100 MHz system clock.
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // The tests need about 30 us; twice that means something has hung.
   initial begin
      #60000;
      num_errors++;
      complete_run();
   end

   initial begin
      int n;
      logic [9:0] v;
      instr_valid_i = 1'b0;
      instr_word0_i = 10'h000;
      instr_word1_i = 10'h000;
      acc_i = 4'h0;
      bank0_register_i = 4'h0;
      rom_page_select_i = 2'h0;
      reg_pair_i = 8'h00;
      status_i = '0;
      slow_timer_clk_i = 1'b0;
      rst_b_i = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      #1;
      rst_b_i = 1'b1;
      chk(timer_preset_o, TMR_RST);
      chk(exec_ready_o, 1'b1);
      $display("reset test done");
      // Every value lands whole in one instruction.
      foreach (vals[i]) begin
         issue(OP_TMR_IMM, imm_word(vals[i]));
         chk(timer_preset_o, vals[i]);
      end
      $display("immediate load test done");
      issue(OP_TMR_IMM, imm_word(10'h3ff));
      acc_i = 4'h5;
      issue(OP_TMR_NIB_WR, 10'h000);
      chk(timer_preset_o, 10'h17d);
      acc_i = 4'ha;
      issue(10'h09f, 10'h000);
      chk(timer_preset_o, 10'h168);
      issue(OP_TMR_NIB_RD, 10'h000);
      chk({acc_we_o, acc_o}, 5'h15);
      issue(10'h39f, 10'h000);
      chk({acc_we_o, acc_o}, 5'h1a);
      $display("nibble test done");
      // Each page value must reach the top address bits.
      for (int p = 0; p < 4; p++) begin
         rom_page_select_i = p[1:0];
         reg_pair_i = 8'h3c ^ 8'(p * 8'h11);
         issue(OP_TMR_ROM, 10'h000);
         v = {rom_page_select_i, reg_pair_i};
         chk(rom_addr_o, v);
         chk(timer_preset_o, v ^ 10'h2c5);
      end
      $display("indirect load test done");
      // All status patterns against all masks, both forms.
      for (int si = 0; si < 32; si++) begin
         status_i = status_in_t'(si[4:0]);
         for (int m = 0; m < 16; m++) begin
            bank0_register_i = m[3:0];
            issue(OP_STATUS_TEST_INSTRUCTION_REG | 10'(m), 10'h000);
            chk(bank0_index_o, m[3:0]);
            chk({status_we_o, flags_o.status_flag},
                {1'b1, |(m[3:0] & live(status_i))});
            issue(OP_STATUS_TEST_INSTRUCTION_IMM, 10'(m));
            chk(flags_o.status_flag, |(m[3:0] & live(status_i)));
         end
      end
      status_i = '0;
      $display("status test done");
      for (int a = 0; a < 16; a++) begin
         acc_i = a[3:0];
         issue(OP_CARRY_ONES, 10'h000);
         chk({carry_we_o, flags_o.carry_flag}, {1'b1, a == 15});
         chk({acc_we_o, acc_o}, {1'b1, ones_run(a[3:0])});
      end
      $display("carry test done");
      // Interval between expiries, for both timer clocks.
      issue(OP_TMR_IMM, imm_word(10'h002));
      period(n);
      period(n);
      chk(n, 3 * TCLK_DIV_LO);
      slow_timer_clk_i = 1'b1;
      issue(OP_TMR_IMM, imm_word(10'h001));
      period(n);
      period(n);
      chk(n, 2 * TCLK_DIV_HI);
      $display("interval test done");
      // Wake on key inputs only; a sense input must not release it.
      issue(OP_STANDBY, 10'h004);
      chk({standby_o, exec_ready_o, wake_select_o}, 6'h24);
      issue(OP_TMR_IMM, imm_word(10'h3aa));
      chk(timer_preset_o, 10'h001);
      status_i.sense_input_a = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk({standby_o, wake_select_o}, 5'h14);
      status_i.key_input_any = 1'b1;
      n = 0;
      while (standby_o !== 1'b0 && n < 4) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      chk(standby_o, 1'b0);
      issue(OP_TMR_IMM, imm_word(10'h3aa));
      chk(timer_preset_o, 10'h3aa);
      $display("standby test done");
      complete_run();
   end
endmodule
`default_nettype wire
